/* verilog/dmgs_pkg.sv */
/*
  Constants for the analog mute, gain and status register bank:
  register offsets, bit positions, write masks, reset values and event slots.
  Assumes an 8-bit register port with 8-bit addresses.
*/

package dmgs_pkg;

    // ------------------------------------------------------------------
    // Port widths
    // ------------------------------------------------------------------
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned DATA_W = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MUTE_MON = 8'h6C;
    localparam logic [7:0] OFS_PIN_LEVEL = 8'h77;
    localparam logic [7:0] OFS_AUTO_MUTE = 8'h78;
    localparam logic [7:0] OFS_AMP_TYPE = 8'h01;
    localparam logic [7:0] OFS_GAIN = 8'h02;
    localparam logic [7:0] OFS_FOLLOW = 8'h06;
    localparam logic [7:0] OFS_BOOST = 8'h07;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h80;
    localparam logic [7:0] OFS_EVT_MASK = 8'h81;

    // ------------------------------------------------------------------
    // Bit positions
    // ------------------------------------------------------------------
    localparam int unsigned BIT_LEFT_MUTE = 1;
    localparam int unsigned BIT_RIGHT_MUTE = 0;
    localparam int unsigned BIT_SER_PIN = 5;
    localparam int unsigned BIT_MUTE_PIN = 4;
    localparam int unsigned BIT_LEFT_AUTO = 4;
    localparam int unsigned BIT_RIGHT_AUTO = 0;
    localparam int unsigned BIT_AMP_SEL = 0;
    localparam int unsigned BIT_LEFT_GAIN = 4;
    localparam int unsigned BIT_RIGHT_GAIN = 0;
    localparam int unsigned BIT_FOLLOW = 0;
    localparam int unsigned BIT_LEFT_BOOST = 4;
    localparam int unsigned BIT_RIGHT_BOOST = 0;

    // ------------------------------------------------------------------
    // Writable bits of each register (stored reserved bits included)
    // ------------------------------------------------------------------
    localparam logic [7:0] WMASK_MUTE_MON = 8'hFC;
    localparam logic [7:0] WMASK_PIN_LEVEL = 8'hC0;
    localparam logic [7:0] WMASK_AUTO_MUTE = 8'hEE;
    localparam logic [7:0] WMASK_FULL = 8'hFF;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_FOLLOW = 8'h01;

    // ------------------------------------------------------------------
    // Event slots, shared by watched levels, status and mask
    // ------------------------------------------------------------------
    localparam int unsigned EV_LEFT_MUTE = 0;
    localparam int unsigned EV_RIGHT_MUTE = 1;
    localparam int unsigned EV_LEFT_AUTO = 2;
    localparam int unsigned EV_RIGHT_AUTO = 3;
    localparam int unsigned EV_MUTE_PIN = 4;
    localparam int unsigned EV_SER_PIN = 5;
    localparam int unsigned NUM_EV = 6;

endpackage

/* verilog/dmgs_level_watch.sv */
/*
  Samples a group of live levels into flops and flags each change.
  Assumes levels are synchronous to the clock.
*/
`timescale 1ns/1ps

module dmgs_level_watch #(
    parameter int unsigned WIDTH = 6
) (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Live levels
    input wire logic [WIDTH-1:0] level_in,
    // Sampled levels and change pulses
    output logic [WIDTH-1:0] level_q,
    output logic [WIDTH-1:0] change_q
);

    // ------------------------------------------------------------------
    // One sampler per level
    // ------------------------------------------------------------------
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            logic level_d;
            logic change_d;

            // Next level and change flag
            always_comb
            begin
                level_d = level_in[i];
                change_d = level_in[i] ^ level_q[i];
            end

            // Registers, cleared to low on reset
            always_ff @(posedge core_clk)
            begin
                if (!nrst)
                begin
                    level_q[i] <= 1'b0;
                    change_q[i] <= 1'b0;
                end
                else
                begin
                    level_q[i] <= level_d;
                    change_q[i] <= change_d;
                end
            end
        end
    endgenerate

endmodule

/* verilog/dmgs_regs.sv */
/*
  Analog mute, gain, boost and status register bank with change events.
  Assumes a simple register port with one-cycle strobes and synchronous
  live inputs from the analog back end and the pins.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/1ps

module dmgs_regs (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [dmgs_pkg::ADDR_W-1:0] reg_addr,
    input wire logic [dmgs_pkg::DATA_W-1:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [dmgs_pkg::DATA_W-1:0] reg_rdata,
    // Live state from analog back end
    input wire logic left_analog_mute_state,
    input wire logic right_analog_mute_state,
    input wire logic left_auto_mute_flag,
    input wire logic right_auto_mute_flag,
    // Pin levels
    input wire logic serial_data_output_pin,
    input wire logic mute_pin,
    // Analog controls
    output logic output_amplitude_select,
    output logic left_gain_select,
    output logic right_gain_select,
    output logic mute_follow_enable,
    output logic left_boost_enable,
    output logic right_boost_enable,
    // Interrupt
    output logic irq
);

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------

    // Merge write data into the writable bits only
    function automatic logic [7:0] merge_write(
        input logic [7:0] cur,
        input logic [7:0] wdata,
        input logic [7:0] wmask
    );
        merge_write = (cur & ~wmask) | (wdata & wmask);
    endfunction

    // Write strobe aimed at one offset
    function automatic logic write_hit(
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] ofs
    );
        write_hit = wr && (addr == ofs);
    endfunction

    // ------------------------------------------------------------------
    // Live level sampling
    // ------------------------------------------------------------------
    logic [dmgs_pkg::NUM_EV-1:0] live_in;
    logic [dmgs_pkg::NUM_EV-1:0] live_q;
    logic [dmgs_pkg::NUM_EV-1:0] live_change;

    // Pack live inputs into event slots
    always_comb
    begin
        live_in = '0;
        live_in[dmgs_pkg::EV_LEFT_MUTE] = left_analog_mute_state;
        live_in[dmgs_pkg::EV_RIGHT_MUTE] = right_analog_mute_state;
        live_in[dmgs_pkg::EV_LEFT_AUTO] = left_auto_mute_flag;
        live_in[dmgs_pkg::EV_RIGHT_AUTO] = right_auto_mute_flag;
        live_in[dmgs_pkg::EV_MUTE_PIN] = mute_pin;
        live_in[dmgs_pkg::EV_SER_PIN] = serial_data_output_pin;
    end

    dmgs_level_watch #(
        .WIDTH(dmgs_pkg::NUM_EV)
    ) u_watch (
        .core_clk(core_clk),
        .nrst(nrst),
        .level_in(live_in),
        .level_q(live_q),
        .change_q(live_change)
    );

    // ------------------------------------------------------------------
    // Change events held off while the first samples after reset settle
    // ------------------------------------------------------------------
    // The sampler leaves reset at low, so a level already high at release
    // would look like a change; changes count from the second edge on
    logic [1:0] settle_q;
    logic [1:0] settle_d;
    logic [dmgs_pkg::NUM_EV-1:0] live_event;

    // Shift a one in behind reset and gate the change pulses with it
    always_comb
    begin
        settle_d = {settle_q[0], 1'b1};
        live_event = live_change & {dmgs_pkg::NUM_EV{settle_q[1]}};
    end

    // Settle register, cleared by reset
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            settle_q <= '0;
        end
        else
        begin
            settle_q <= settle_d;
        end
    end

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    logic [7:0] mute_mon_q;
    logic [7:0] mute_mon_d;
    logic [7:0] pin_level_q;
    logic [7:0] pin_level_d;
    logic [7:0] auto_mute_q;
    logic [7:0] auto_mute_d;
    logic [7:0] amp_type_q;
    logic [7:0] amp_type_d;
    logic [7:0] gain_q;
    logic [7:0] gain_d;
    logic [7:0] follow_q;
    logic [7:0] follow_d;
    logic [7:0] boost_q;
    logic [7:0] boost_d;
    logic [dmgs_pkg::NUM_EV-1:0] evt_status_q;
    logic [dmgs_pkg::NUM_EV-1:0] evt_status_d;
    logic [dmgs_pkg::NUM_EV-1:0] evt_mask_q;
    logic [dmgs_pkg::NUM_EV-1:0] evt_mask_d;
    logic [dmgs_pkg::NUM_EV-1:0] evt_clear;
    logic irq_q;
    logic irq_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic [7:0] read_val;

    // Next values of the writable registers; read-only bits never stored
    always_comb
    begin
        mute_mon_d = mute_mon_q;
        pin_level_d = pin_level_q;
        auto_mute_d = auto_mute_q;
        amp_type_d = amp_type_q;
        gain_d = gain_q;
        follow_d = follow_q;
        boost_d = boost_q;
        evt_mask_d = evt_mask_q;
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_MUTE_MON))
        begin
            mute_mon_d = merge_write(mute_mon_q, reg_wdata, dmgs_pkg::WMASK_MUTE_MON);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_PIN_LEVEL))
        begin
            pin_level_d = merge_write(pin_level_q, reg_wdata, dmgs_pkg::WMASK_PIN_LEVEL);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_AUTO_MUTE))
        begin
            auto_mute_d = merge_write(auto_mute_q, reg_wdata, dmgs_pkg::WMASK_AUTO_MUTE);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_AMP_TYPE))
        begin
            amp_type_d = merge_write(amp_type_q, reg_wdata, dmgs_pkg::WMASK_FULL);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_GAIN))
        begin
            gain_d = merge_write(gain_q, reg_wdata, dmgs_pkg::WMASK_FULL);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_FOLLOW))
        begin
            follow_d = merge_write(follow_q, reg_wdata, dmgs_pkg::WMASK_FULL);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_BOOST))
        begin
            boost_d = merge_write(boost_q, reg_wdata, dmgs_pkg::WMASK_FULL);
        end
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_EVT_MASK))
        begin
            evt_mask_d = reg_wdata[dmgs_pkg::NUM_EV-1:0];
        end
    end

    // ------------------------------------------------------------------
    // Event status, write one to clear, a new change wins over the clear
    // ------------------------------------------------------------------
    always_comb
    begin
        evt_clear = '0;
        if (write_hit(reg_wr, reg_addr, dmgs_pkg::OFS_EVT_STATUS))
        begin
            evt_clear = reg_wdata[dmgs_pkg::NUM_EV-1:0];
        end
        evt_status_d = (evt_status_q & ~evt_clear) | live_event;
        irq_d = |(evt_status_d & evt_mask_d);
    end

    // ------------------------------------------------------------------
    // Read path, no side effects; live bits merged with stored ones
    // ------------------------------------------------------------------
    always_comb
    begin
        read_val = 8'h00;
        case (reg_addr)
            dmgs_pkg::OFS_MUTE_MON:
            begin
                read_val = mute_mon_q;
                read_val[dmgs_pkg::BIT_LEFT_MUTE] = live_q[dmgs_pkg::EV_LEFT_MUTE];
                read_val[dmgs_pkg::BIT_RIGHT_MUTE] = live_q[dmgs_pkg::EV_RIGHT_MUTE];
            end
            dmgs_pkg::OFS_PIN_LEVEL:
            begin
                read_val = pin_level_q;
                read_val[dmgs_pkg::BIT_SER_PIN] = live_q[dmgs_pkg::EV_SER_PIN];
                read_val[dmgs_pkg::BIT_MUTE_PIN] = live_q[dmgs_pkg::EV_MUTE_PIN];
            end
            dmgs_pkg::OFS_AUTO_MUTE:
            begin
                read_val = auto_mute_q;
                read_val[dmgs_pkg::BIT_LEFT_AUTO] = live_q[dmgs_pkg::EV_LEFT_AUTO];
                read_val[dmgs_pkg::BIT_RIGHT_AUTO] = live_q[dmgs_pkg::EV_RIGHT_AUTO];
            end
            dmgs_pkg::OFS_AMP_TYPE:
            begin
                read_val = amp_type_q;
            end
            dmgs_pkg::OFS_GAIN:
            begin
                read_val = gain_q;
            end
            dmgs_pkg::OFS_FOLLOW:
            begin
                read_val = follow_q;
            end
            dmgs_pkg::OFS_BOOST:
            begin
                read_val = boost_q;
            end
            dmgs_pkg::OFS_EVT_STATUS:
            begin
                read_val[dmgs_pkg::NUM_EV-1:0] = evt_status_q;
            end
            dmgs_pkg::OFS_EVT_MASK:
            begin
                read_val[dmgs_pkg::NUM_EV-1:0] = evt_mask_q;
            end
            default:
            begin
                read_val = 8'h00;
            end
        endcase
        rdata_d = reg_rd ? read_val : 8'h00;
    end

    // ------------------------------------------------------------------
    // Register all state except the settle register
    // ------------------------------------------------------------------
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            mute_mon_q <= dmgs_pkg::RST_ZERO;
            pin_level_q <= dmgs_pkg::RST_ZERO;
            auto_mute_q <= dmgs_pkg::RST_ZERO;
            amp_type_q <= dmgs_pkg::RST_ZERO;
            gain_q <= dmgs_pkg::RST_ZERO;
            follow_q <= dmgs_pkg::RST_FOLLOW;
            boost_q <= dmgs_pkg::RST_ZERO;
            evt_status_q <= '0;
            evt_mask_q <= '0;
            irq_q <= 1'b0;
            rdata_q <= dmgs_pkg::RST_ZERO;
        end
        else
        begin
            mute_mon_q <= mute_mon_d;
            pin_level_q <= pin_level_d;
            auto_mute_q <= auto_mute_d;
            amp_type_q <= amp_type_d;
            gain_q <= gain_d;
            follow_q <= follow_d;
            boost_q <= boost_d;
            evt_status_q <= evt_status_d;
            evt_mask_q <= evt_mask_d;
            irq_q <= irq_d;
            rdata_q <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Outputs, each straight from a flop
    // ------------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign irq = irq_q;
    assign output_amplitude_select = amp_type_q[dmgs_pkg::BIT_AMP_SEL];
    assign left_gain_select = gain_q[dmgs_pkg::BIT_LEFT_GAIN];
    assign right_gain_select = gain_q[dmgs_pkg::BIT_RIGHT_GAIN];
    assign mute_follow_enable = follow_q[dmgs_pkg::BIT_FOLLOW];
    assign left_boost_enable = boost_q[dmgs_pkg::BIT_LEFT_BOOST];
    assign right_boost_enable = boost_q[dmgs_pkg::BIT_RIGHT_BOOST];

endmodule

/* dv/dmgs_regs_properties.sv */
/*
  Checker for the mute, gain and status register bank.
  Sees only the ports of dmgs_regs; bound at the foot of this file.
*/
`timescale 1ns/1ps

module dmgs_regs_checker (
    // Clock and reset
    input wire logic core_clk,
    input wire logic nrst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Live state and pins
    input wire logic left_analog_mute_state,
    input wire logic right_analog_mute_state,
    input wire logic left_auto_mute_flag,
    input wire logic right_auto_mute_flag,
    input wire logic serial_data_output_pin,
    input wire logic mute_pin,
    // Controls and interrupt
    input wire logic output_amplitude_select,
    input wire logic left_gain_select,
    input wire logic right_gain_select,
    input wire logic mute_follow_enable,
    input wire logic left_boost_enable,
    input wire logic right_boost_enable,
    input wire logic irq
);
    // ----------
    // Access shapes
    // ----------
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!nrst);

    // Read taken last edge at offset a, live sample past reset
    sequence rd_at(logic [7:0] a);
        $past(reg_rd) && $past(reg_addr) == a && $past(nrst, 2);
    endsequence

    // Write taken last edge at offset a
    sequence wr_at(logic [7:0] a);
        $past(reg_wr) && $past(reg_addr) == a;
    endsequence

    // ----------
    // Assertions
    // ----------
    chk_mute_monitor: assert property (rd_at(8'h6C) |->
        reg_rdata[1:0] == {$past(left_analog_mute_state, 2),
        $past(right_analog_mute_state, 2)}) else $error("mute monitor bits wrong");
    chk_pin_levels: assert property (rd_at(8'h77) |->
        reg_rdata[5:4] == {$past(serial_data_output_pin, 2), $past(mute_pin, 2)})
        else $error("pin level bits wrong");
    chk_auto_flags: assert property (rd_at(8'h78) |->
        {reg_rdata[4], reg_rdata[0]} == {$past(left_auto_mute_flag, 2),
        $past(right_auto_mute_flag, 2)}) else $error("auto mute bits wrong");
    chk_amp_select: assert property (wr_at(8'h01) |->
        output_amplitude_select == $past(reg_wdata[0])) else $error("amplitude select");
    chk_gain_write: assert property (wr_at(8'h02) |->
        {left_gain_select, right_gain_select} == {$past(reg_wdata[4]), $past(reg_wdata[0])})
        else $error("gain select wrong");
    chk_follow_write: assert property (wr_at(8'h06) |->
        mute_follow_enable == $past(reg_wdata[0])) else $error("follow enable wrong");
    chk_boost_write: assert property (wr_at(8'h07) |->
        {left_boost_enable, right_boost_enable} == {$past(reg_wdata[4]),
        $past(reg_wdata[0])}) else $error("boost enable wrong");
    chk_ctrl_hold: assert property (!$past(reg_wr) |-> $stable({output_amplitude_select,
        left_gain_select, right_gain_select, mute_follow_enable, left_boost_enable,
        right_boost_enable})) else $error("control changed without write");
    chk_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not idle");

    // Main scenarios
    cov_mute_read: cover property (rd_at(8'h6C));
    cov_gain_write: cover property (wr_at(8'h02));
    cov_irq_rise: cover property ($rose(irq));
endmodule

bind dmgs_regs dmgs_regs_checker chk_i (.*);

/* dv/dmgs_regs_bench.sv */
/*
  Self-checking bench for the mute, gain and status register bank.
  Drives every input port of dmgs_regs directly; one clock at 200 MHz.
*/
`timescale 1ns/1ps

module dmgs_regs_bench;
    logic core_clk, nrst, reg_wr, reg_rd, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, got;
    logic left_analog_mute_state, right_analog_mute_state, left_auto_mute_flag;
    logic right_auto_mute_flag, serial_data_output_pin, mute_pin;
    logic output_amplitude_select, left_gain_select, right_gain_select;
    logic mute_follow_enable, left_boost_enable, right_boost_enable;
    logic [7:0] m [0:255];
    logic [7:0] pick [9] = '{8'h6C, 8'h77, 8'h78, 8'h01, 8'h02, 8'h06, 8'h07, 8'h03, 8'h7F};
    int fails, checked;

    dmgs_regs uut (.*);

    // Clock
    initial
    begin
        core_clk = 1'b0;
        forever #2.5 core_clk = ~core_clk;
    end

    // ----------
    // Compare and bus tasks
    // ----------
    task automatic chk8(input logic [7:0] g, input logic [7:0] e);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %0t byte %h expected %h", $time, g, e);
        end
    endtask

    task automatic chk1(input logic g, input logic e);
        checked++;
        if (g !== e)
        begin
            fails++;
            $display("MISMATCH %0t bit %b expected %b", $time, g, e);
        end
    endtask

    // One write cycle, then a gap; model keeps the byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        m[a] = d;
        @(posedge core_clk);
    endtask

    // One read cycle; data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
        @(posedge core_clk);
    endtask

    // Live levels change, then one edge samples them
    task automatic live(input logic [5:0] v);
        {left_analog_mute_state, right_analog_mute_state, left_auto_mute_flag,
            right_auto_mute_flag, serial_data_output_pin, mute_pin} <= v;
        @(posedge core_clk);
    endtask

    task automatic do_reset();
        nrst <= 1'b0;
        repeat (2) @(posedge core_clk);
        nrst <= 1'b1;
        @(posedge core_clk);
        foreach (m[i]) m[i] = 8'h00;
        m[8'h06] = dmgs_pkg::RST_FOLLOW;
    endtask

    // Expected read value: stored bits under mask, live bits merged
    function automatic logic [7:0] exp_rd(input logic [7:0] a);
        case (a)
            8'h6C: return (m[a] & dmgs_pkg::WMASK_MUTE_MON)
                | {6'h00, left_analog_mute_state, right_analog_mute_state};
            8'h77: return (m[a] & dmgs_pkg::WMASK_PIN_LEVEL)
                | {2'b00, serial_data_output_pin, mute_pin, 4'h0};
            8'h78: return (m[a] & dmgs_pkg::WMASK_AUTO_MUTE)
                | {3'b000, left_auto_mute_flag, 3'b000, right_auto_mute_flag};
            8'h01, 8'h02, 8'h06, 8'h07: return m[a];
            default: return 8'h00;
        endcase
    endfunction

    // Reads every mapped register except event status and mask, and one hole, checks control outputs
    task automatic check_all();
        for (int i = 0; i < 8; i++)
        begin
            rd(pick[i], got);
            chk8(got, exp_rd(pick[i]));
        end
        chk1(output_amplitude_select, m[8'h01][0]);
        chk1(left_gain_select, m[8'h02][4]);
        chk1(right_gain_select, m[8'h02][0]);
        chk1(mute_follow_enable, m[8'h06][0]);
        chk1(left_boost_enable, m[8'h07][4]);
        chk1(right_boost_enable, m[8'h07][0]);
    endtask

    task automatic summarize();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        {nrst, reg_wr, reg_rd, reg_addr, reg_wdata} = '0;
        {left_analog_mute_state, right_analog_mute_state, left_auto_mute_flag} = '0;
        {right_auto_mute_flag, serial_data_output_pin, mute_pin} = '0;
        fails = 0;
        checked = 0;
        void'($urandom(78428));
        do_reset();
        check_all();
        // Supply tracking mode; the clock setup stays with software
        wr(8'h01, 8'h01);
        check_all();
        // Random writes to the picked offsets, holes included, with random live levels; mask is clear
        repeat (40)
        begin
            live(6'($urandom));
            wr(pick[$urandom_range(0, 8)], 8'($urandom));
            chk1(irq, 1'b0);
            check_all();
        end
        // Interrupt: clear, raise on pin change, mask, unmask, clear
        live(6'h00);
        repeat (2) @(posedge core_clk);
        wr(8'h80, 8'h3F);
        wr(8'h81, 8'h10);
        chk1(irq, 1'b0);
        live(6'h01);
        repeat (3) @(posedge core_clk);
        chk1(irq, 1'b1);
        rd(8'h80, got);
        chk8(got, 8'h10);
        wr(8'h81, 8'h00);
        chk1(irq, 1'b0);
        wr(8'h81, 8'h10);
        chk1(irq, 1'b1);
        wr(8'h80, 8'h10);
        chk1(irq, 1'b0);
        // Serial pin event in the same cycle as its clear: the event stays
        live(6'h03);
        wr(8'h80, 8'h20);
        rd(8'h80, got);
        chk8(got, 8'h20);
        // Reset in mid-run brings back reset values
        wr(8'h06, 8'h00);
        do_reset();
        check_all();
        chk1(irq, 1'b0);
        // Levels held high across reset raise no event
        rd(8'h80, got);
        chk8(got, 8'h00);
        summarize();
    end

    // Watchdog
    initial
    begin
        #100000;
        fails++;
        summarize();
    end
endmodule
